//--- hw/ambient_regs.svh
`ifndef AMBIENT_REGS_SVH
`define AMBIENT_REGS_SVH

// ************************************************
// Register addresses
// ************************************************
`define AMB_ADDR_PARAM 8'h84
`define AMB_ADDR_RES_HI 8'h85
`define AMB_ADDR_RES_LO 8'h86

// ************************************************
// Parameter register fields and reset
// ************************************************
`define AMB_CONT_BIT 7
`define AMB_RATE_HI 6
`define AMB_RATE_LO 4
`define AMB_OFS_BIT 3
`define AMB_AVG_HI 2
`define AMB_AVG_LO 0
`define AMB_PARAM_RESET 8'h0d

// ************************************************
// Timing
// ************************************************
`define AMB_CLK_HZ 25000000
`define AMB_GAP_CYCLES 5'h10

`endif

//--- hw/ambient_pkg.sv
package ambient_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OFS_REQ,
      ST_OFS_WAIT,
      ST_CONV_REQ,
      ST_CONV_WAIT,
      ST_GAP
   } amb_state_t;

   typedef struct packed {
      logic cont;
      logic [2:0] rate;
      logic ofs_en;
      logic [2:0] avg;
   } amb_param_t;

   typedef struct packed {
      amb_param_t param_r;
      amb_param_t active_r;
      logic [15:0] result_r;
      amb_state_t state_r;
      logic [22:0] acc_r;
      logic [15:0] offset_r;
      logic [7:0] cnt_r;
      logic [31:0] timer_r;
      logic [4:0] gap_r;
      logic [7:0] rdata_r;
      logic st_prev_r;
      logic req_prev_r;
      logic ready_r;
   } amb_regs_t;

endpackage

//--- hw/ambient_light_param_result.sv
// Functional notes
// R1: Parameter register at 84h, readable and writable.
// R2: Bit 7 enables back-to-back conversions; reset zero.
// R3: Host uses back-to-back only with single-shot, never self-timed.
// R4: Bit 3 enables automatic offset compensation; reset one.
// R5: With compensation, measure offset before each run and subtract it.
// R6: Bits 2:0 give conversions per run as two to the code.
// R7: Stored result is the mean of the run's conversions.
// R8: Averaging field resets to 101, thirty-two conversions.
// R9: New parameters wait until self-timed mode is cycled.
// R10: 16-bit result, high byte at 85h, low byte at 86h.
// R11: Result registers read-only; 15:8 and 7:0; writes ignored.
// R12: Host changes parameters only while single-shot request is zero.
// R13: Host changes rates only while self-timed enable is clear.
// R14: Bits 6:4 hold the rate code; 000 is one sample per second.
`include "ambient_regs.svh"

module ambient_light_param_result #(
   parameter int unsigned CLK_HZ = `AMB_CLK_HZ
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic selftimed_en,
   input wire logic ambient_periodic_en,
   input wire logic ambient_single_shot_request,
   output logic conv_start,
   output logic conv_is_offset,
   input wire logic conv_done,
   input wire logic [15:0] conv_data,
   output logic ambient_busy,
   output logic ambient_data_ready
);

   ambient_pkg::amb_regs_t q_r;
   ambient_pkg::amb_regs_t q_nxt;
   logic [7:0] param_bits;
   logic [7:0] run_len;
   logic [15:0] sample;
   logic [22:0] acc_sum;
   logic [31:0] period;
   logic tick;
   logic od_go;

   // ************************************************
   // Derived terms
   // ************************************************
   assign param_bits = q_r.param_r;
   assign run_len = 8'(1 << q_r.active_r.avg); // R6
   // Offset subtraction clamps at zero rather than wrapping
   assign sample = (q_r.active_r.ofs_en && conv_data > q_r.offset_r) ?
      conv_data - q_r.offset_r :
      (q_r.active_r.ofs_en ? 16'h0000 : conv_data); // R5
   assign acc_sum = q_r.acc_r + {7'h00, sample};
   assign period = 32'(CLK_HZ / (32'(q_r.active_r.rate) + 32'h1)); // R14
   assign tick = selftimed_en && ambient_periodic_en &&
      (q_r.timer_r == 32'h0);
   // Single-shot is ignored while self-timed runs
   assign od_go = !selftimed_en && ambient_single_shot_request &&
      !q_r.req_prev_r;

   assign conv_start = (q_r.state_r == ambient_pkg::ST_OFS_REQ) ||
      (q_r.state_r == ambient_pkg::ST_CONV_REQ);
   assign conv_is_offset = (q_r.state_r == ambient_pkg::ST_OFS_REQ) ||
      (q_r.state_r == ambient_pkg::ST_OFS_WAIT);
   assign ambient_busy = (q_r.state_r != ambient_pkg::ST_IDLE);
   assign ambient_data_ready = q_r.ready_r;
   assign reg_rdata = q_r.rdata_r;

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      q_nxt = q_r;
      q_nxt.ready_r = 1'b0;
      q_nxt.st_prev_r = selftimed_en;
      q_nxt.req_prev_r = ambient_single_shot_request;

      if (reg_wr && reg_addr == `AMB_ADDR_PARAM) begin
         q_nxt.param_r = reg_wdata; // R1 R2 R4 R14
      end
      // Writes to result addresses fall through untouched R11

      // Working copy tracks the register outside self-timed mode and in its first cycle
      if (!selftimed_en || !q_r.st_prev_r) begin
         q_nxt.active_r = q_nxt.param_r; // R9
      end

      if (reg_rd) begin
         case (reg_addr)
            `AMB_ADDR_PARAM: q_nxt.rdata_r = param_bits; // R1
            `AMB_ADDR_RES_HI: q_nxt.rdata_r = q_r.result_r[15:8]; // R10 R11
            `AMB_ADDR_RES_LO: q_nxt.rdata_r = q_r.result_r[7:0]; // R10 R11
            default: q_nxt.rdata_r = 8'h00;
         endcase
      end

      if (!selftimed_en || !ambient_periodic_en || tick) begin
         q_nxt.timer_r = period - 32'h1;
      end else begin
         q_nxt.timer_r = q_r.timer_r - 32'h1;
      end

      case (q_r.state_r)
         ambient_pkg::ST_IDLE: begin
            q_nxt.acc_r = 23'h0;
            q_nxt.cnt_r = 8'h00;
            if (tick || od_go) begin
               q_nxt.state_r = q_r.active_r.ofs_en ?
                  ambient_pkg::ST_OFS_REQ : ambient_pkg::ST_CONV_REQ; // R5
            end
         end
         ambient_pkg::ST_OFS_REQ: q_nxt.state_r = ambient_pkg::ST_OFS_WAIT;
         ambient_pkg::ST_OFS_WAIT: begin
            if (conv_done) begin
               q_nxt.offset_r = conv_data; // R5
               q_nxt.state_r = ambient_pkg::ST_CONV_REQ;
            end
         end
         ambient_pkg::ST_CONV_REQ: q_nxt.state_r = ambient_pkg::ST_CONV_WAIT;
         ambient_pkg::ST_CONV_WAIT: begin
            if (conv_done) begin
               q_nxt.acc_r = acc_sum;
               q_nxt.cnt_r = q_r.cnt_r + 8'h01;
               if (q_r.cnt_r + 8'h01 == run_len) begin
                  q_nxt.result_r = 16'(acc_sum >> q_r.active_r.avg); // R7
                  q_nxt.ready_r = 1'b1;
                  q_nxt.state_r = ambient_pkg::ST_IDLE;
               end else if (q_r.active_r.cont) begin
                  q_nxt.state_r = ambient_pkg::ST_CONV_REQ; // R2
               end else begin
                  // Without back-to-back mode a settle gap is inserted
                  q_nxt.gap_r = `AMB_GAP_CYCLES;
                  q_nxt.state_r = ambient_pkg::ST_GAP;
               end
            end
         end
         ambient_pkg::ST_GAP: begin
            q_nxt.gap_r = q_r.gap_r - 5'h01;
            if (q_r.gap_r == 5'h01) begin
               q_nxt.state_r = ambient_pkg::ST_CONV_REQ;
            end
         end
         default: q_nxt.state_r = ambient_pkg::ST_IDLE;
      endcase
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q_r <= '0;
         q_r.param_r <= `AMB_PARAM_RESET; // R2 R4 R8 R14
         q_r.active_r <= `AMB_PARAM_RESET; // R8
         q_r.state_r <= ambient_pkg::ST_IDLE;
      end else begin
         q_r <= q_nxt;
      end
   end

endmodule

//--- dv/ambient_adc_model.sv
module ambient_adc_model (
   input wire logic sys_clk,
   input wire logic conv_start,
   input wire logic conv_is_offset,
   input wire logic slow,
   input wire logic [15:0] ofs_v,
   input wire logic [15:0] smp_v,
   output logic conv_done,
   output logic [15:0] conv_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] v;
   initial begin
      conv_done = 1'b0;
      conv_data = 16'h0;
      forever begin
         @(posedge sys_clk);
         if (conv_start) begin
            v = conv_is_offset ? ofs_v : smp_v;
            repeat (slow ? 5 : 1) @(posedge sys_clk);
            {conv_done, conv_data} <= {1'b1, v};
            @(posedge sys_clk);
            // Stale data inverted so a late sample cannot pass
            {conv_done, conv_data} <= {1'b0, ~v};
         end
      end
   end
endmodule

//--- dv/ambient_light_param_result_monitor.sv
module ambient_light_param_result_monitor (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic selftimed_en,
   input wire logic ambient_single_shot_request,
   input wire logic conv_start,
   input wire logic conv_is_offset,
   input wire logic conv_done,
   input wire logic ambient_busy,
   input wire logic ambient_data_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   param_rdback_a: assert property (reg_wr && reg_addr == 8'h84
      ##1 reg_rd && !reg_wr && reg_addr == 8'h84
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("rdback");
   unmapped_rd_a: assert property (reg_rd && (reg_addr < 8'h84 ||
      reg_addr > 8'h86) |=> reg_rdata == 8'h0) else $error("unmapped");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("rdata moved");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("start len");
   start_busy_a: assert property (conv_start |-> ambient_busy)
      else $error("start idle");
   ready_done_a: assert property (ambient_data_ready |->
      $past(conv_done) && !ambient_busy) else $error("ready");
   shot_start_a: assert property ($rose(ambient_single_shot_request)
      && !selftimed_en && !ambient_busy |=> conv_start && ambient_busy)
      else $error("shot");
   ofs_first_a: assert property (conv_start && conv_is_offset |->
      $rose(ambient_busy)) else $error("offset late");
endmodule
bind ambient_light_param_result ambient_light_param_result_monitor i_mon (
   .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .selftimed_en(selftimed_en), .conv_start(conv_start),
   .ambient_single_shot_request(ambient_single_shot_request),
   .conv_is_offset(conv_is_offset), .conv_done(conv_done),
   .ambient_busy(ambient_busy), .ambient_data_ready(ambient_data_ready));

//--- dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic st = 1'b0, shot = 1'b0, slow = 1'b0, conv_start, conv_is_offset;
   logic conv_done, ambient_busy, ambient_data_ready;
   logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
   logic [15:0] conv_data, ofs_v = 16'h0010, smp_v = 16'h1234;
   logic [15:0] nst = 16'h0, base = 16'h0;
   int error_cnt = 0, check_count = 0, cyc;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (conv_start === 1'b1) nst <= nst + 16'h1;
   ambient_light_param_result #(.CLK_HZ(400)) i_dut (.sys_clk(sys_clk),
      .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .selftimed_en(st), .ambient_periodic_en(st),
      .ambient_single_shot_request(shot), .conv_start(conv_start),
      .conv_is_offset(conv_is_offset), .conv_done(conv_done),
      .conv_data(conv_data), .ambient_busy(ambient_busy),
      .ambient_data_ready(ambient_data_ready));
   ambient_adc_model i_adc (.sys_clk(sys_clk), .conv_start(conv_start),
      .conv_is_offset(conv_is_offset), .slow(slow), .ofs_v(ofs_v),
      .smp_v(smp_v), .conv_done(conv_done), .conv_data(conv_data));
   task automatic finish_test;
      if (error_cnt == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk({8'h0, reg_rdata}, {8'h0, exp});
   endtask
   task automatic rdback_burst(input logic [7:0] d);
      @(negedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, 8'h84, d};
      @(negedge sys_clk);
      {reg_wr, reg_rd} = 2'b01;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk({8'h0, reg_rdata}, {8'h0, d});
   endtask
   task automatic wait_ready;
      for (cyc = 0; cyc < 4000 && ambient_data_ready !== 1'b1; cyc++)
         @(negedge sys_clk);
      if (cyc == 4000) begin
         chk(16'h0, 16'h1);
         finish_test();
      end
   endtask
   task automatic run(input logic [7:0] p, input logic [15:0] n,
      input logic [15:0] r);
      wr(8'h84, p);
      base = nst;
      shot = 1'b1;
      wait_ready();
      shot = 1'b0;
      chk(nst - base, n);
      rd(8'h85, r[15:8]);
      rd(8'h86, r[7:0]);
   endtask
   task automatic reset_values;
      rd(8'h84, 8'h0d);
      rd(8'h85, 8'h00);
   endtask
   task automatic reg_access;
      wr(8'h85, 8'hff);
      rd(8'h85, 8'h00);
      rd(8'h90, 8'h00);
      rd(8'h80, 8'h00);
      wr(8'h84, 8'hf8);
      rd(8'h84, 8'hf8);
   endtask
   task automatic conv_modes;
      run(8'h0a, 16'h5, 16'h1224);
      slow = 1'b1;
      run(8'h01, 16'h2, 16'h1234);
      slow = 1'b0;
      run(8'h81, 16'h2, 16'h1234);
      chk({15'h0, cyc < 12}, 16'h1);
   endtask
   task automatic avg_sweep;
      for (int i = 0; i < 8; i++)
         run({5'h10, i[2:0]}, 16'h1 << i, 16'h1234);
   endtask
   task automatic selftimed_freeze;
      wr(8'h84, 8'h00);
      st = 1'b1;
      repeat (3) @(negedge sys_clk);
      wr(8'h84, 8'h03);
      base = nst;
      wait_ready();
      chk(nst - base, 16'h1);
      st = 1'b0;
      rd(8'h84, 8'h03);
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      nrst = 1'b1;
      reset_values();
      reg_access();
      rdback_burst(8'h5a);
      conv_modes();
      avg_sweep();
      selftimed_freeze();
      finish_test();
   end
endmodule
